/* File: pkg/ild_cfg.svh */
// Constants of the input loop divider and charge pump register bank.
// Assumes an 8-bit register space addressed by a 12-bit serial-port address.
`ifndef ILD_CFG_SVH
`define ILD_CFG_SVH

`define ILD_ADDR_W         12
`define ILD_NUM_REGS       10
`define ILD_IDX_W          4

// Register byte addresses.
`define ILD_BASE_ADDR      12'h010
`define ILD_OFS_PRI_LO     12'h010
`define ILD_OFS_PRI_HI     12'h011
`define ILD_OFS_SEC_LO     12'h012
`define ILD_OFS_SEC_HI     12'h013
`define ILD_OFS_TEST       12'h014
`define ILD_OFS_RSVD       12'h015
`define ILD_OFS_FB_LO      12'h016
`define ILD_OFS_FB_HI      12'h017
`define ILD_OFS_PUMP_CUR   12'h018
`define ILD_OFS_PUMP_MODE  12'h019

// Writable bit masks; masked-off bits are reserved.
`define ILD_MASK_LOW_BYTE  8'hFF
`define ILD_MASK_HIGH_PAIR 8'h03
`define ILD_MASK_TEST      8'h3F
`define ILD_MASK_RSVD      8'h00
`define ILD_MASK_PUMP_CUR  8'hFF
`define ILD_MASK_PUMP_MODE 8'h1F

// Register reset values.
`define ILD_RST_DIV        8'h00
`define ILD_RST_PUMP_CUR   8'h00
`define ILD_RST_PUMP_MODE  8'h0B

// Field positions.
`define ILD_POS_PUMP_TRI   7
`define ILD_POS_CUR_MSB    6
`define ILD_POS_ABL_CTRL   4
`define ILD_POS_ABL_MSB    3
`define ILD_POS_ABL_LSB    2
`define ILD_POS_MODE_MSB   1
`define ILD_POS_MODE_LSB   0
`define ILD_POS_HIGH_MSB   1

// Reset values of the derived outputs.
`define ILD_RST_RATIO10    10'h001
`define ILD_RST_RATIO6     6'h01
`define ILD_RST_CUR        7'h00

`endif

/* File: pkg/ild_pkg.sv */
// Types shared by the input loop divider and charge pump register bank.
// Assumes the constants of ild_cfg.svh for widths of the register words.
package ild_pkg;

  // Phase detector antibacklash period.
  typedef enum logic [1:0] {
    ILD_ABL_MIN  = 2'h0,
    ILD_ABL_LOW  = 2'h1,
    ILD_ABL_HIGH = 2'h2,
    ILD_ABL_MAX  = 2'h3
  } ild_abl_type;

  // Charge pump operating mode.
  typedef enum logic [1:0] {
    ILD_PUMP_TRISTATE = 2'h0,
    ILD_PUMP_UP       = 2'h1,
    ILD_PUMP_DOWN     = 2'h2,
    ILD_PUMP_NORMAL   = 2'h3
  } ild_pump_mode_type;

  // Staging and active copy of one buffered register.
  typedef struct packed {
    logic [7:0] staged;
    logic [7:0] active;
  } ild_cell_state_type;

  // Registered outputs of the bank.
  typedef struct packed {
    logic [7:0]        rdata;
    logic              rd_hit;
    logic [9:0]        pri_ratio;
    logic [9:0]        sec_ratio;
    logic [5:0]        test_ratio;
    logic [9:0]        fb_ratio;
    logic [6:0]        cur;
    logic              tri_st;
    ild_pump_mode_type mode;
    logic              abl_auto;
    ild_abl_type       abl_period;
  } ild_regs_state_type;

endpackage : ild_pkg

/* File: src/ild_stage_cell.sv */
// One buffered 8-bit register: a staging copy written by software and an
// active copy loaded on the I/O update strobe. Assumes same-clock strobes.
`timescale 1ns/1ps
`include "ild_cfg.svh"

module ild_stage_cell #(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF
) (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  input  wire logic       io_update,
  input  wire logic       soft_reset,
  output logic      [7:0] staged_out,
  output logic      [7:0] active_out
);

  ild_pkg::ild_cell_state_type st_r;
  ild_pkg::ild_cell_state_type st_nxt;

  // Soft reset wins over everything; an update moves the old staged word.
  always_comb begin
    st_nxt = st_r;
    if (soft_reset) begin
      st_nxt.staged = RST_VAL;
      st_nxt.active = RST_VAL;
    end else begin
      if (io_update) begin
        st_nxt.active = st_r.staged;
      end
      if (wr_en) begin
        st_nxt.staged = wr_data & WR_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{staged: RST_VAL, active: RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign staged_out = st_r.staged;
  assign active_out = st_r.active;

  a_soft_restore: assert property (@(posedge sys_clk) disable iff (!arst_n)
    soft_reset |=> (st_r.staged == RST_VAL) && (st_r.active == RST_VAL))
    else $error("Soft reset did not restore the register defaults.");

  a_update_apply: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (io_update && !soft_reset) |=> st_r.active == $past(st_r.staged))
    else $error("Update strobe did not apply the staged word.");

  a_active_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!io_update && !soft_reset) |=> $stable(st_r.active))
    else $error("Active word changed without an update strobe.");

  a_reserved_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ((st_r.staged & ~WR_MASK) == 8'h00) && ((st_r.active & ~WR_MASK) == 8'h00))
    else $error("Reserved bit was set in a register.");

endmodule : ild_stage_cell

/* File: src/ild_ratio_norm.sv */
// Turns a divider word into its division ratio: zero and one both divide
// by one. Pure combinational; the caller registers the result.
`timescale 1ns/1ps

module ild_ratio_norm #(
  parameter int W = 10
) (
  input  wire logic [W-1:0] word,
  output logic      [W-1:0] ratio
);

  // A zero word cannot divide, so it is folded onto a ratio of one.
  always_comb begin
    ratio = word;
    if (word == '0) begin
      ratio = W'(1);
    end
  end

endmodule : ild_ratio_norm

/* File: src/ild_regs.sv */
// Input loop register bank: reference, test and feedback divider words and
// charge pump controls, with staging copies applied on the I/O update.
// Assumes the serial control port decodes frames on sys_clk and presents
// one byte access at a time; the strobes arrive on the same clock.
`timescale 1ns/1ps
`include "ild_cfg.svh"

module ild_regs #(
  parameter int NUM_REGS = `ILD_NUM_REGS
) (
  input  wire logic                         sys_clk,
  input  wire logic                         arst_n,
  input  wire logic [`ILD_ADDR_W-1:0]       reg_addr,
  input  wire logic                         reg_wr_en,
  input  wire logic [7:0]                   reg_wdata,
  input  wire logic                         reg_rd_en,
  output logic      [7:0]                   reg_rdata,
  output logic                              reg_rd_hit,
  input  wire logic                         io_update,
  input  wire logic                         soft_reset,
  input  wire logic                         readback_staged,
  input  wire logic                         secondary_indep,
  output logic      [9:0]                   primary_ratio,
  output logic      [9:0]                   secondary_ratio,
  output logic      [5:0]                   test_ratio,
  output logic      [9:0]                   feedback_ratio,
  output logic      [6:0]                   pump_current,
  output logic                              pump_tristate,
  output ild_pkg::ild_pump_mode_type        pump_mode,
  output logic                              abl_auto,
  output ild_pkg::ild_abl_type              abl_period
);

  // Address decode, shared by the write path and the read path.
  function automatic logic in_bank(input logic [`ILD_ADDR_W-1:0] addr);
    in_bank = (addr >= `ILD_BASE_ADDR) &&
              (addr < (`ILD_BASE_ADDR + `ILD_ADDR_W'(NUM_REGS)));
  endfunction : in_bank

  function automatic logic [`ILD_IDX_W-1:0] bank_index(input logic [`ILD_ADDR_W-1:0] addr);
    logic [`ILD_ADDR_W-1:0] diff;
    diff       = addr - `ILD_BASE_ADDR;
    bank_index = diff[`ILD_IDX_W-1:0];
  endfunction : bank_index

  // Writable bits of each register; anything outside is reserved.
  function automatic logic [7:0] reg_mask(input int idx);
    logic [`ILD_ADDR_W-1:0] ofs;
    ofs = `ILD_BASE_ADDR + `ILD_ADDR_W'(idx);
    case (ofs)
      `ILD_OFS_PRI_LO:    reg_mask = `ILD_MASK_LOW_BYTE;
      `ILD_OFS_PRI_HI:    reg_mask = `ILD_MASK_HIGH_PAIR;
      `ILD_OFS_SEC_LO:    reg_mask = `ILD_MASK_LOW_BYTE;
      `ILD_OFS_SEC_HI:    reg_mask = `ILD_MASK_HIGH_PAIR;
      `ILD_OFS_TEST:      reg_mask = `ILD_MASK_TEST;
      `ILD_OFS_FB_LO:     reg_mask = `ILD_MASK_LOW_BYTE;
      `ILD_OFS_FB_HI:     reg_mask = `ILD_MASK_HIGH_PAIR;
      `ILD_OFS_PUMP_CUR:  reg_mask = `ILD_MASK_PUMP_CUR;
      `ILD_OFS_PUMP_MODE: reg_mask = `ILD_MASK_PUMP_MODE;
      default:            reg_mask = `ILD_MASK_RSVD;
    endcase
  endfunction : reg_mask

  // Default value of each register.
  function automatic logic [7:0] reg_reset(input int idx);
    logic [`ILD_ADDR_W-1:0] ofs;
    ofs = `ILD_BASE_ADDR + `ILD_ADDR_W'(idx);
    case (ofs)
      `ILD_OFS_PUMP_CUR:  reg_reset = `ILD_RST_PUMP_CUR;
      `ILD_OFS_PUMP_MODE: reg_reset = `ILD_RST_PUMP_MODE;
      default:            reg_reset = `ILD_RST_DIV;
    endcase
  endfunction : reg_reset

  logic [7:0]              staged_w [0:NUM_REGS-1];
  logic [7:0]              active_w [0:NUM_REGS-1];
  logic                    acc_hit;
  logic [`ILD_IDX_W-1:0]   acc_idx;

  assign acc_hit = in_bank(reg_addr);
  assign acc_idx = bank_index(reg_addr);

  // One staged cell per register; reserved bits are masked inside the cell.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_cell
      ild_stage_cell #(
        .RST_VAL (reg_reset(gi)),
        .WR_MASK (reg_mask(gi))
      ) u_cell (
        .sys_clk    (sys_clk),
        .arst_n     (arst_n),
        .wr_en      (reg_wr_en && acc_hit && (acc_idx == `ILD_IDX_W'(gi))),
        .wr_data    (reg_wdata),
        .io_update  (io_update),
        .soft_reset (soft_reset),
        .staged_out (staged_w[gi]),
        .active_out (active_w[gi])
      );
    end
  endgenerate

  // Divider words assembled from the active copies of their register pairs; the test word comes from one register.
  logic [9:0] pri_word;
  logic [9:0] sec_word;
  logic [5:0] test_word;
  logic [9:0] fb_word;
  logic [7:0] pump_cur_reg;
  logic [7:0] pump_mode_reg;

  assign pri_word      = {active_w[1][`ILD_POS_HIGH_MSB:0], active_w[0]};
  assign sec_word      = {active_w[3][`ILD_POS_HIGH_MSB:0], active_w[2]};
  assign test_word     = active_w[4][5:0];
  assign fb_word       = {active_w[7][`ILD_POS_HIGH_MSB:0], active_w[6]};
  assign pump_cur_reg  = active_w[8];
  assign pump_mode_reg = active_w[9];

  logic [9:0] pri_norm;
  logic [9:0] sec_norm;
  logic [5:0] test_norm;
  logic [9:0] fb_norm;

  // Ratio normalisation; each divider folds a zero word onto one.
  ild_ratio_norm #(.W(10)) u_pri_norm (
    .word  (pri_word),
    .ratio (pri_norm)
  );

  ild_ratio_norm #(.W(10)) u_sec_norm (
    .word  (sec_word),
    .ratio (sec_norm)
  );

  ild_ratio_norm #(.W(6)) u_test_norm (
    .word  (test_word),
    .ratio (test_norm)
  );

  ild_ratio_norm #(.W(10)) u_fb_norm (
    .word  (fb_word),
    .ratio (fb_norm)
  );

  ild_pkg::ild_regs_state_type st_r;
  ild_pkg::ild_regs_state_type st_nxt;

  // Next state of the read port and of the registered loop controls.
  // Outputs lag the active copies by one cycle so every output is a flop.
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rd_hit = 1'b0;
    if (reg_rd_en) begin
      st_nxt.rd_hit = acc_hit;
      st_nxt.rdata  = 8'h00;
      if (acc_hit) begin
        if (readback_staged) begin
          st_nxt.rdata = staged_w[acc_idx];
        end else begin
          st_nxt.rdata = active_w[acc_idx];
        end
      end
    end
    st_nxt.pri_ratio  = pri_norm;
    // Without independent mode the secondary path reuses the primary ratio.
    st_nxt.sec_ratio  = secondary_indep ? sec_norm : pri_norm;
    st_nxt.test_ratio = test_norm;
    st_nxt.fb_ratio   = fb_norm;
    st_nxt.cur        = pump_cur_reg[`ILD_POS_CUR_MSB:0];
    st_nxt.mode       = ild_pkg::ild_pump_mode_type'(
                          pump_mode_reg[`ILD_POS_MODE_MSB:`ILD_POS_MODE_LSB]);
    // The high-impedance override and the tristate mode both float the pump.
    st_nxt.tri_st     = pump_cur_reg[`ILD_POS_PUMP_TRI] ||
                        (st_nxt.mode == ild_pkg::ILD_PUMP_TRISTATE);
    st_nxt.abl_auto   = !pump_mode_reg[`ILD_POS_ABL_CTRL];
    if (pump_mode_reg[`ILD_POS_ABL_CTRL]) begin
      st_nxt.abl_period = ild_pkg::ild_abl_type'(
                            pump_mode_reg[`ILD_POS_ABL_MSB:`ILD_POS_ABL_LSB]);
    end else begin
      st_nxt.abl_period = ild_pkg::ILD_ABL_HIGH;
    end
  end

  // Register the whole state; reset values match the register defaults.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r.rdata      <= 8'h00;
      st_r.rd_hit     <= 1'b0;
      st_r.pri_ratio  <= `ILD_RST_RATIO10;
      st_r.sec_ratio  <= `ILD_RST_RATIO10;
      st_r.test_ratio <= `ILD_RST_RATIO6;
      st_r.fb_ratio   <= `ILD_RST_RATIO10;
      st_r.cur        <= `ILD_RST_CUR;
      st_r.tri_st     <= 1'b0;
      st_r.mode       <= ild_pkg::ILD_PUMP_NORMAL;
      st_r.abl_auto   <= 1'b1;
      st_r.abl_period <= ild_pkg::ILD_ABL_HIGH;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata       = st_r.rdata;
  assign reg_rd_hit      = st_r.rd_hit;
  assign primary_ratio   = st_r.pri_ratio;
  assign secondary_ratio = st_r.sec_ratio;
  assign test_ratio      = st_r.test_ratio;
  assign feedback_ratio  = st_r.fb_ratio;
  assign pump_current    = st_r.cur;
  assign pump_tristate   = st_r.tri_st;
  assign pump_mode       = st_r.mode;
  assign abl_auto        = st_r.abl_auto;
  assign abl_period      = st_r.abl_period;

  // Checks on the bank as a whole.
  sequence s_bank_read;
    reg_rd_en && acc_hit;
  endsequence

  sequence s_stray_read;
    reg_rd_en && !acc_hit;
  endsequence

  sequence s_write_then_update;
    (reg_wr_en && acc_hit && (acc_idx == `ILD_IDX_W'(0)) && !soft_reset && !io_update)
      ##1 (io_update && !soft_reset && !reg_wr_en);
  endsequence

  a_read_answer: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_bank_read |=> reg_rd_hit)
    else $error("Read inside the bank was not answered.");

  a_stray_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_stray_read |=> (!reg_rd_hit && (reg_rdata == 8'h00)))
    else $error("Read outside the bank returned data.");

  a_primary_lands: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_write_then_update |=> ##1 (primary_ratio[7:0] ==
      (($past(reg_wdata, 3) == 8'h00) && (primary_ratio[9:8] == 2'h0) ?
        8'h01 : $past(reg_wdata, 3))))
    else $error("Primary low byte did not reach the ratio after update.");

  a_ratio_floor: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (primary_ratio != 10'h000) && (secondary_ratio != 10'h000))
    else $error("Reference ratio of zero was driven.");

  a_secondary_follow: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !secondary_indep |=> (secondary_ratio == primary_ratio))
    else $error("Secondary ratio did not follow the primary one.");

  a_test_floor: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (test_word == 6'h00) |=> (test_ratio == 6'h01))
    else $error("Test divider zero word did not give one.");

  a_feedback_floor: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (fb_word == 10'h000) |=> (feedback_ratio == 10'h001))
    else $error("Feedback zero word did not give one.");

  a_pump_float: assert property (@(posedge sys_clk) disable iff (!arst_n)
    pump_cur_reg[`ILD_POS_PUMP_TRI] |=> pump_tristate)
    else $error("Tristate bit did not float the pump.");

  a_pump_current: assert property (@(posedge sys_clk) disable iff (!arst_n)
    1'b1 |=> (pump_current == $past(pump_cur_reg[`ILD_POS_CUR_MSB:0])))
    else $error("Pump current did not track its field.");

  a_abl_select: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !pump_mode_reg[`ILD_POS_ABL_CTRL] |=> (abl_auto && (abl_period == ild_pkg::ILD_ABL_HIGH)))
    else $error("Automatic antibacklash did not use the high period.");

  a_mode_track: assert property (@(posedge sys_clk) disable iff (!arst_n)
    1'b1 |=> (pump_mode == $past(pump_mode_reg[`ILD_POS_MODE_MSB:`ILD_POS_MODE_LSB])))
    else $error("Pump mode did not track its field.");

endmodule : ild_regs

/* File: tb/test_ild_regs.sv */
// Self-checking bench for the input loop register bank: divider words, pump fields,
// staging and readback, reserved bits and both resets.
// Assumes the bank sits on sys_clk with byte accesses driven straight at its ports.
`timescale 1ns/1ps
`include "ild_cfg.svh"

module test_ild_regs;
  typedef struct packed {
    logic [9:0] pri;
    logic [9:0] sec;
    logic [7:0] tst;
    logic [9:0] fb;
    logic [7:0] cur;
    logic [7:0] mode;
    logic       ind;
    logic [9:0] e_pri;
    logic [9:0] e_sec;
    logic [5:0] e_tst;
    logic [9:0] e_fb;
    logic       e_tri;
    logic [1:0] e_per;
  } ild_row_type;

  logic                       sys_clk         = 1'b0;
  logic                       arst_n          = 1'b0;
  logic [`ILD_ADDR_W-1:0]     reg_addr        = 12'h000;
  logic                       reg_wr_en       = 1'b0;
  logic [7:0]                 reg_wdata       = 8'h00;
  logic                       reg_rd_en       = 1'b0;
  logic                       io_update       = 1'b0;
  logic                       soft_reset      = 1'b0;
  logic                       readback_staged = 1'b0;
  logic                       secondary_indep = 1'b0;
  logic [7:0]                 reg_rdata;
  logic                       reg_rd_hit;
  logic [9:0]                 primary_ratio;
  logic [9:0]                 secondary_ratio;
  logic [5:0]                 test_ratio;
  logic [9:0]                 feedback_ratio;
  logic [6:0]                 pump_current;
  logic                       pump_tristate;
  ild_pkg::ild_pump_mode_type pump_mode;
  logic                       abl_auto;
  ild_pkg::ild_abl_type       abl_period;
  logic [7:0]                 img [10];
  ild_row_type                r;
  int                         fails = 0;
  int                         checks_done = 0;

  // Rows cover every pump mode and antibacklash setting, both bounds of each word except the secondary one.
  ild_row_type rows [5] = '{
    '{10'h000, 10'h001, 8'h00, 10'h001, 8'h00, 8'h1B, 1'b1,
      10'h001, 10'h001, 6'h01, 10'h001, 1'b0, 2'h2},
    '{10'h3FF, 10'h2AA, 8'hFF, 10'h3FF, 8'h7F, 8'h1C, 1'b1,
      10'h3FF, 10'h2AA, 6'h3F, 10'h3FF, 1'b1, 2'h3},
    '{10'h155, 10'h00F, 8'h02, 10'h002, 8'h80, 8'h11, 1'b0,
      10'h155, 10'h155, 6'h02, 10'h002, 1'b1, 2'h0},
    '{10'h002, 10'h3FE, 8'h01, 10'h000, 8'h2A, 8'h16, 1'b1,
      10'h002, 10'h3FE, 6'h01, 10'h001, 1'b0, 2'h1},
    '{10'h001, 10'h100, 8'h3E, 10'h200, 8'h55, 8'hE7, 1'b1,
      10'h001, 10'h100, 6'h3E, 10'h200, 1'b0, 2'h2}
  };

  ild_regs dut_u (
    .sys_clk         (sys_clk),
    .arst_n          (arst_n),
    .reg_addr        (reg_addr),
    .reg_wr_en       (reg_wr_en),
    .reg_wdata       (reg_wdata),
    .reg_rd_en       (reg_rd_en),
    .reg_rdata       (reg_rdata),
    .reg_rd_hit      (reg_rd_hit),
    .io_update       (io_update),
    .soft_reset      (soft_reset),
    .readback_staged (readback_staged),
    .secondary_indep (secondary_indep),
    .primary_ratio   (primary_ratio),
    .secondary_ratio (secondary_ratio),
    .test_ratio      (test_ratio),
    .feedback_ratio  (feedback_ratio),
    .pump_current    (pump_current),
    .pump_tristate   (pump_tristate),
    .pump_mode       (pump_mode),
    .abl_auto        (abl_auto),
    .abl_period      (abl_period)
  );

  // Free-running 100 MHz clock.
  always #5 sys_clk = ~sys_clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  // Case inequality so that an unknown never passes for a match.
  task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One byte write; the strobe drops a full edge later so calls never collide.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
  endtask : wr

  // Writes a bank register and keeps the value that should read back.
  task automatic wr_reg(input int i, input logic [7:0] d, input logic [7:0] m);
    wr(`ILD_BASE_ADDR + 12'(i), d);
    img[i] = d & m;
  endtask : wr_reg

  // The hit flag stands for one cycle only, so the answer is looked at right after the sampling edge.
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic h, input logic s);
    @(posedge sys_clk);
    reg_addr        <= a;
    readback_staged <= s;
    reg_rd_en       <= 1'b1;
    @(posedge sys_clk);
    reg_rd_en <= 1'b0;
    #1;
    check("reg_rd_hit", reg_rd_hit, h);
    check("reg_rdata", reg_rdata, e);
  endtask : rd

  // Applies the staged copies.
  task automatic upd();
    @(posedge sys_clk);
    io_update <= 1'b1;
    @(posedge sys_clk);
    io_update <= 1'b0;
  endtask : upd

  // Lets active copies reach the registered outputs.
  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask : settle

  task automatic chk_out(input logic [9:0] p, input logic [9:0] s, input logic [5:0] t,
                         input logic [9:0] f, input logic [6:0] c, input logic tr,
                         input logic [1:0] m, input logic au, input logic [1:0] pe);
    check("primary_ratio", primary_ratio, p);
    check("secondary_ratio", secondary_ratio, s);
    check("test_ratio", test_ratio, {4'h0, t});
    check("feedback_ratio", feedback_ratio, f);
    check("pump_current", pump_current, {3'h0, c});
    check("pump_tristate", pump_tristate, tr);
    check("pump_mode", pump_mode, m);
    check("abl_auto", abl_auto, au);
    check("abl_period", abl_period, pe);
  endtask : chk_out

  // Default outputs, then both copies of every register.
  task automatic defaults();
    chk_out(10'h001, 10'h001, 6'h01, 10'h001, 7'h00, 1'b0, 2'h3, 1'b1, 2'h2);
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 10; i++) begin
        rd(`ILD_BASE_ADDR + 12'(i), (i == 9) ? 8'h0B : 8'h00, 1'b1, s[0]);
      end
    end
  endtask : defaults

  // Cuts a hang short.
  initial begin
    #200000;
    fails++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int n = 0; n < 5; n++) begin
      r = rows[n];
      secondary_indep <= r.ind;
      wr_reg(0, r.pri[7:0], 8'hFF);
      wr_reg(1, {6'h2A, r.pri[9:8]}, 8'h03);
      wr_reg(2, r.sec[7:0], 8'hFF);
      wr_reg(3, {6'h15, r.sec[9:8]}, 8'h03);
      wr_reg(4, r.tst, 8'h3F);
      wr_reg(5, 8'hFF, 8'h00);
      wr_reg(6, r.fb[7:0], 8'hFF);
      wr_reg(7, {6'h3F, r.fb[9:8]}, 8'h03);
      wr_reg(8, r.cur, 8'hFF);
      wr_reg(9, r.mode, 8'h1F);
      upd();
      settle();
      chk_out(r.e_pri, r.e_sec, r.e_tst, r.e_fb, r.cur[6:0], r.e_tri,
              r.mode[1:0], ~r.mode[4], r.e_per);
      for (int i = 0; i < 10; i++) begin
        rd(`ILD_BASE_ADDR + 12'(i), img[i], 1'b1, 1'b0);
      end
      $display("test row %0d done", n);
    end
    // A staged word waits for the update; a write in the update cycle stays staged.
    wr(12'h010, 8'h44);
    wr(12'h011, 8'h01);
    rd(12'h010, 8'h44, 1'b1, 1'b1);
    rd(12'h010, 8'h01, 1'b1, 1'b0);
    settle();
    check("primary_ratio", primary_ratio, 10'h001);
    @(posedge sys_clk);
    reg_addr  <= 12'h010;
    reg_wdata <= 8'h66;
    reg_wr_en <= 1'b1;
    io_update <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    io_update <= 1'b0;
    settle();
    check("primary_ratio", primary_ratio, 10'h144);
    rd(12'h010, 8'h66, 1'b1, 1'b1);
    upd();
    settle();
    check("primary_ratio", primary_ratio, 10'h166);
    // A write followed at once by the update reaches the ratio three edges later.
    @(posedge sys_clk);
    reg_addr  <= 12'h010;
    reg_wdata <= 8'h00;
    reg_wr_en <= 1'b1;
    @(posedge sys_clk);
    reg_wr_en <= 1'b0;
    io_update <= 1'b1;
    @(posedge sys_clk);
    io_update <= 1'b0;
    settle();
    check("primary_ratio", primary_ratio, 10'h100);
    $display("test staging done");
    // Accesses outside the bank are refused and never alias into it.
    wr(12'h110, 8'hFF);
    rd(12'h010, 8'h00, 1'b1, 1'b1);
    rd(12'h01A, 8'h00, 1'b0, 1'b0);
    rd(12'h00F, 8'h00, 1'b0, 1'b0);
    rd(12'h810, 8'h00, 1'b0, 1'b0);
    $display("test bounds done");
    // Soft reset wins over a write and an update in the same cycle.
    @(posedge sys_clk);
    soft_reset <= 1'b1;
    reg_addr   <= 12'h019;
    reg_wdata  <= 8'h1C;
    reg_wr_en  <= 1'b1;
    io_update  <= 1'b1;
    @(posedge sys_clk);
    soft_reset <= 1'b0;
    reg_wr_en  <= 1'b0;
    io_update  <= 1'b0;
    settle();
    defaults();
    $display("test soft reset done");
    // Hardware reset in mid-run.
    wr(12'h018, 8'h8F);
    upd();
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk_out(10'h001, 10'h001, 6'h01, 10'h001, 7'h00, 1'b0, 2'h3, 1'b1, 2'h2);
    @(posedge sys_clk);
    arst_n <= 1'b1;
    defaults();
    $display("test hard reset done");
    stop_test();
  end
endmodule : test_ild_regs
